// File: design/tick_timer_pkg.sv
// constants for the 8-bit period match timer
package tick_timer_pkg;
  // register addresses (plain port, word per register)
  localparam logic [2:0] ADDR_COUNT  = 3'h0;
  localparam logic [2:0] ADDR_PERIOD = 3'h1;
  localparam logic [2:0] ADDR_CTRL   = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_MASK   = 3'h4;
  // control field positions
  localparam int CTRL_PRE_LSB  = 0;
  localparam int CTRL_RUN_BIT  = 2;
  localparam int CTRL_POST_LSB = 3;
  // status / mask bit position of the match flag
  localparam int MATCH_FLAG_BIT = 1;
  // reset values
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [6:0] CTRL_RST   = 7'h00;
  // instruction clock is the core clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // prescale terminal counts (ratio minus one)
  localparam logic [3:0] PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hf;
endpackage

// File: design/period_match_timer_8bit.sv
// 8-bit period match timer with prescaler, postscaler and interrupt
// How it works
// - counter advances on instruction ticks (clock divided by four) through the prescaler
// - prescale code 00 divides by 1, 01 by 4, 1x by 16
// - counter counts up from 00h, returns to 00h after matching period
// - period register is read/write and resets to ffh
// - counter register is read/write and reset clears it
// - match events pass a 4-bit postscaler before the interrupt flag
// - postscale ratio equals control bits 6:3 plus one
// - postscaler output sets the match flag at status bit 1
// - writing the counter clears prescaler and postscaler
// - writing control clears prescaler and postscaler
// - every device reset clears prescaler and postscaler
// - writing control leaves the counter value unchanged
// - control bit 2 runs the timer, clearing it halts counting
// - control bit 7 reads zero, implemented bits reset to zero
// - raw match pulse before postscaling goes to the serial port
// - counter and match pulse are offered as the pwm time base
`timescale 1ns/1ps
module period_match_timer_8bit
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            irq,
  output logic            match_pulse,
  output logic      [7:0] pwm_count,
  output logic            pwm_match
);

  logic [7:0] count_r;
  logic [7:0] period_r;
  logic [6:0] ctrl_r;
  logic [1:0] instr_div_r;
  logic [3:0] pre_cnt_r;
  logic [3:0] post_cnt_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [3:0] pre_last;
  logic       instr_tick;
  logic       pre_tick;
  logic       match_now;
  logic       post_fire;
  logic       wr_count;
  logic       wr_ctrl;
  logic       scaler_clr;
  logic       run;
  logic [3:0] post_last;
  logic [7:0] rdata_nxt;

  // write decode
  assign wr_count   = wr && (addr == tick_timer_pkg::ADDR_COUNT);
  assign wr_ctrl    = wr && (addr == tick_timer_pkg::ADDR_CTRL);
  assign scaler_clr = wr_count || wr_ctrl;
  assign run        = ctrl_r[tick_timer_pkg::CTRL_RUN_BIT];
  assign post_last  = ctrl_r[tick_timer_pkg::CTRL_POST_LSB +: 4];

  // prescale terminal count select
  always_comb
  begin
    if (ctrl_r[tick_timer_pkg::CTRL_PRE_LSB + 1])
      pre_last = tick_timer_pkg::PRE_LAST_16;
    else if (ctrl_r[tick_timer_pkg::CTRL_PRE_LSB])
      pre_last = tick_timer_pkg::PRE_LAST_4;
    else
      pre_last = tick_timer_pkg::PRE_LAST_1;
  end

  assign instr_tick = run && (instr_div_r == tick_timer_pkg::INSTR_DIV_LAST);
  assign pre_tick   = instr_tick && (pre_cnt_r == pre_last) && !scaler_clr;
  assign match_now  = pre_tick && (count_r == period_r) && !wr_count;
  assign post_fire  = match_now && (post_cnt_r == post_last);

  // instruction clock divider, frozen while halted
  always_ff @(posedge clk)
  begin
    if (srst)
      instr_div_r <= 2'h0;
    else if (scaler_clr)
      instr_div_r <= 2'h0;
    else if (run)
      instr_div_r <= instr_div_r + 2'h1;
  end

  // prescaler
  always_ff @(posedge clk)
  begin
    if (srst)
      pre_cnt_r <= 4'h0;
    else if (scaler_clr)
      pre_cnt_r <= 4'h0;
    else if (instr_tick)
    begin
      if (pre_cnt_r >= pre_last)
        pre_cnt_r <= 4'h0;
      else
        pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end

  // tick counter; control writes do not touch it
  always_ff @(posedge clk)
  begin
    if (srst)
      count_r <= tick_timer_pkg::COUNT_RST;
    else if (wr_count)
      count_r <= wdata;
    else if (pre_tick)
    begin
      if (count_r == period_r)
        count_r <= 8'h00;
      else
        count_r <= count_r + 8'h01;
    end
  end

  // postscaler
  always_ff @(posedge clk)
  begin
    if (srst)
      post_cnt_r <= 4'h0;
    else if (scaler_clr)
      post_cnt_r <= 4'h0;
    else if (match_now)
    begin
      if (post_cnt_r >= post_last)
        post_cnt_r <= 4'h0;
      else
        post_cnt_r <= post_cnt_r + 4'h1;
    end
  end

  // period and control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      period_r <= tick_timer_pkg::PERIOD_RST;
      ctrl_r   <= tick_timer_pkg::CTRL_RST;
    end
    else
    begin
      if (wr && addr == tick_timer_pkg::ADDR_PERIOD)
        period_r <= wdata;
      if (wr_ctrl)
        ctrl_r <= wdata[6:0];
    end
  end

  // sticky status, set wins over write-one-to-clear; mask register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_r <= 8'h00;
      mask_r   <= 8'h00;
    end
    else
    begin
      if (wr && addr == tick_timer_pkg::ADDR_STATUS)
        status_r[tick_timer_pkg::MATCH_FLAG_BIT] <=
          post_fire || (status_r[tick_timer_pkg::MATCH_FLAG_BIT]
                        && !wdata[tick_timer_pkg::MATCH_FLAG_BIT]);
      else if (post_fire)
        status_r[tick_timer_pkg::MATCH_FLAG_BIT] <= 1'b1;
      if (wr && addr == tick_timer_pkg::ADDR_MASK)
        mask_r[tick_timer_pkg::MATCH_FLAG_BIT] <= wdata[tick_timer_pkg::MATCH_FLAG_BIT];
    end
  end

  // interrupt level, registered
  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

  // time base outputs for serial port and pwm
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      match_pulse <= 1'b0;
      pwm_match   <= 1'b0;
      pwm_count   <= 8'h00;
    end
    else
    begin
      match_pulse <= match_now;
      pwm_match   <= match_now;
      pwm_count   <= count_r;
    end
  end

  // read mux
  always_comb
  begin
    unique case (addr)
      tick_timer_pkg::ADDR_COUNT:  rdata_nxt = count_r;
      tick_timer_pkg::ADDR_PERIOD: rdata_nxt = period_r;
      tick_timer_pkg::ADDR_CTRL:   rdata_nxt = {1'b0, ctrl_r};
      tick_timer_pkg::ADDR_STATUS: rdata_nxt = status_r;
      tick_timer_pkg::ADDR_MASK:   rdata_nxt = mask_r;
      default:                     rdata_nxt = 8'h00;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 8'h00;
  end

  // checks
  property p_wrap;
    @(posedge clk) disable iff (srst)
      (pre_tick && count_r == period_r && !wr_count) |=> count_r == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_inc;
    @(posedge clk) disable iff (srst)
      (pre_tick && count_r != period_r && !wr_count) |=> count_r == $past(count_r) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not advance");

  property p_halt;
    @(posedge clk) disable iff (srst)
      (!run && !wr) |=> $stable(count_r) && $stable(pre_cnt_r) && $stable(post_cnt_r);
  endproperty
  a_halt: assert property (p_halt) else $error("halted timer moved");

  property p_wr_count;
    @(posedge clk) disable iff (srst)
      wr_count |=> pre_cnt_r == 4'h0 && post_cnt_r == 4'h0 && count_r == $past(wdata);
  endproperty
  a_wr_count: assert property (p_wr_count) else $error("counter write wrong");

  property p_wr_ctrl;
    @(posedge clk) disable iff (srst)
      wr_ctrl |=> pre_cnt_r == 4'h0 && post_cnt_r == 4'h0 && $stable(count_r);
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write wrong");

  property p_reset;
    @(posedge clk) srst |=> count_r == 8'h00 && period_r == 8'hff && ctrl_r == 7'h00
      && pre_cnt_r == 4'h0 && post_cnt_r == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  property p_flag;
    @(posedge clk) disable iff (srst)
      post_fire |=> status_r[1];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  property p_irq;
    @(posedge clk) disable iff (srst)
      (status_r[1] && mask_r[1]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_pulse;
    @(posedge clk) disable iff (srst)
      match_now |=> match_pulse && pwm_match;
  endproperty
  a_pulse: assert property (p_pulse) else $error("match pulse missing");

  property p_ctrl_read;
    @(posedge clk) disable iff (srst)
      (rd && addr == tick_timer_pkg::ADDR_CTRL) |=> rdata[7] == 1'b0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("bit 7 not zero");

  // instruction ticks are four core clocks apart
  property p_instr_gap;
    @(posedge clk) disable iff (srst)
      instr_tick |=> !instr_tick [*3];
  endproperty
  a_instr_gap: assert property (p_instr_gap) else $error("tick spacing wrong");

  // divider holds while halted and untouched
  property p_instr_halt;
    @(posedge clk) disable iff (srst)
      (!run && !wr) |=> $stable(instr_div_r);
  endproperty
  a_instr_halt: assert property (p_instr_halt) else $error("divider moved");

  // halted timer never reports a match
  property p_match_halt;
    @(posedge clk) disable iff (srst)
      !run |-> !match_now;
  endproperty
  a_match_halt: assert property (p_match_halt) else $error("match while halted");

  // prescaler never passes its selected terminal count
  property p_pre_range;
    @(posedge clk) disable iff (srst)
      pre_cnt_r <= pre_last;
  endproperty
  a_pre_range: assert property (p_pre_range) else $error("prescaler out of range");

  // postscaler never passes its selected terminal count
  property p_post_range;
    @(posedge clk) disable iff (srst)
      post_cnt_r <= post_last;
  endproperty
  a_post_range: assert property (p_post_range) else $error("postscaler out of range");

  // control write lands in the implemented bits
  property p_ctrl_wr;
    @(posedge clk) disable iff (srst)
      wr_ctrl |=> ctrl_r == $past(wdata[6:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  // period write lands as written
  property p_period_wr;
    @(posedge clk) disable iff (srst)
      (wr && addr == tick_timer_pkg::ADDR_PERIOD) |=> period_r == $past(wdata);
  endproperty
  a_period_wr: assert property (p_period_wr) else $error("period write lost");

  // counter read returns the value held at the strobe
  property p_rd_count;
    @(posedge clk) disable iff (srst)
      (rd && addr == tick_timer_pkg::ADDR_COUNT) |=> rdata == $past(count_r);
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("counter read wrong");

  // flag stays set until a one is written to it
  property p_flag_hold;
    @(posedge clk) disable iff (srst)
      (status_r[1] && !(wr && addr == tick_timer_pkg::ADDR_STATUS && wdata[1]))
        |=> status_r[1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  // writing a one clears the flag unless a fire lands in the same cycle
  property p_flag_clear;
    @(posedge clk) disable iff (srst)
      (wr && addr == tick_timer_pkg::ADDR_STATUS && wdata[1] && !post_fire)
        |=> !status_r[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  // interrupt drops once flag or enable is gone
  property p_irq_low;
    @(posedge clk) disable iff (srst)
      !(status_r[1] && mask_r[1]) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq without cause");

  // no time base pulse without a raw match
  property p_pulse_low;
    @(posedge clk) disable iff (srst)
      !match_now |=> !match_pulse && !pwm_match;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("stray match pulse");

  // pwm count follows the counter one cycle late
  property p_pwm_count;
    @(posedge clk) disable iff (srst)
      1'b1 |=> pwm_count == $past(count_r);
  endproperty
  a_pwm_count: assert property (p_pwm_count) else $error("pwm count wrong");

  // outputs and flags are quiet after any reset
  property p_reset_out;
    @(posedge clk) srst |=> !irq && !match_pulse && !pwm_match
      && rdata == 8'h00 && status_r == 8'h00 && mask_r == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not quiet");

  c_match: cover property (@(posedge clk) disable iff (srst) match_now);
  c_fire: cover property (@(posedge clk) disable iff (srst) post_fire);
  c_irq: cover property (@(posedge clk) disable iff (srst) $rose(irq));
  c_clear_race: cover property (@(posedge clk) disable iff (srst)
    post_fire && wr && addr == tick_timer_pkg::ADDR_STATUS);
  c_halt: cover property (@(posedge clk) disable iff (srst) wr_ctrl && !wdata[2]);

endmodule

// File: tb/testbench.sv
// register-level testbench for the 8-bit period match timer
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       match_pulse;
  logic [7:0] pwm_count;
  logic       pwm_match;
  int         bad_count = 0;
  int         checks_done = 0;
  int         n;
  int         g;
  int         r;
  int         posts[3] = '{0, 3, 15};

  // 100 MHz core clock
  always #5 clk = ~clk;

  period_match_timer_8bit dut_u (
    .clk         (clk),
    .srst        (srst),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdata),
    .irq         (irq),
    .match_pulse (match_pulse),
    .pwm_count   (pwm_count),
    .pwm_match   (pwm_match)
  );

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // cycles until the raw match pulse shows, bounded
  task automatic wait_pulse(output int cnt);
    cnt = 0;
    while (match_pulse !== 1'b1 && cnt < 5000)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  // watchdog well beyond the expected run length
  initial
  begin
    #500000;
    bad_count++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk(tick_timer_pkg::ADDR_COUNT, 8'h00);
    rd_chk(tick_timer_pkg::ADDR_PERIOD, 8'hff);
    rd_chk(tick_timer_pkg::ADDR_CTRL, 8'h00);
    rd_chk(tick_timer_pkg::ADDR_STATUS, 8'h00);
    rd_chk(3'h5, 8'h00);
    wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h83);
    rd_chk(tick_timer_pkg::ADDR_CTRL, 8'h03);
    wr_reg(tick_timer_pkg::ADDR_COUNT, 8'h5a);
    repeat (40) @(posedge clk);
    rd_chk(tick_timer_pkg::ADDR_COUNT, 8'h5a);
    check(pwm_count, 8'h5a);
    wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h78);
    rd_chk(tick_timer_pkg::ADDR_COUNT, 8'h5a);
    wr_reg(tick_timer_pkg::ADDR_PERIOD, 8'h3c);
    rd_chk(tick_timer_pkg::ADDR_PERIOD, 8'h3c);
    wr_reg(tick_timer_pkg::ADDR_COUNT, 8'h00);
    wr_reg(tick_timer_pkg::ADDR_PERIOD, 8'h03);
    // match spacing for every prescale code, period 3
    for (int c = 0; c < 4; c++)
    begin
      r = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h04 | c[7:0]);
      wait_pulse(n);
      @(posedge clk);
      #1;
      wait_pulse(n);
      check({7'h00, (n + 1) == 16 * r}, 8'h01);
      check({7'h00, pwm_match}, 8'h01);
    end
    // scaler clear by counter write, then by control write
    wr_reg(tick_timer_pkg::ADDR_PERIOD, 8'h00);
    for (int op = 0; op < 2; op++)
    begin
      wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h06);
      wait_pulse(n);
      repeat (30) @(posedge clk);
      wr_reg(op == 0 ? tick_timer_pkg::ADDR_COUNT : tick_timer_pkg::ADDR_CTRL,
             op == 0 ? 8'h00 : 8'h06);
      wait_pulse(n);
      check({7'h00, n >= 60 && n <= 68}, 8'h01);
    end
    // postscale ratios counted in match pulses before the interrupt
    wr_reg(tick_timer_pkg::ADDR_PERIOD, 8'h01);
    wr_reg(tick_timer_pkg::ADDR_MASK, 8'h02);
    foreach (posts[i])
    begin
      wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h00);
      wr_reg(tick_timer_pkg::ADDR_STATUS, 8'h02);
      wr_reg(tick_timer_pkg::ADDR_CTRL, {1'b0, posts[i][3:0], 3'b100});
      n = 0;
      g = 0;
      while (irq !== 1'b1 && g < 2000)
      begin
        @(posedge clk);
        #1;
        g++;
        if (match_pulse === 1'b1)
          n++;
      end
      check(8'(n), 8'(posts[i] + 1));
    end
    // sticky flag, mask gating and clear
    wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h00);
    rd_chk(tick_timer_pkg::ADDR_STATUS, 8'h02);
    wr_reg(tick_timer_pkg::ADDR_MASK, 8'h00);
    @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    wr_reg(tick_timer_pkg::ADDR_MASK, 8'h02);
    @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h01);
    wr_reg(tick_timer_pkg::ADDR_STATUS, 8'h02);
    @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    // second reset in mid-run, timer running and flag raised
    wr_reg(tick_timer_pkg::ADDR_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h01);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({7'h00, irq}, 8'h00);
    rd_chk(tick_timer_pkg::ADDR_PERIOD, 8'hff);
    rd_chk(tick_timer_pkg::ADDR_CTRL, 8'h00);
    rd_chk(tick_timer_pkg::ADDR_COUNT, 8'h00);
    rd_chk(tick_timer_pkg::ADDR_STATUS, 8'h00);
    finish_test();
  end
endmodule
